// ### hw/scmr_pkg.sv
package scmr_pkg;

  // Register offsets
  localparam logic [11:0] OFS_SPEED_COMMAND_CONTROL = 12'h0E8;
  localparam logic [11:0] OFS_COMMANDED_DUTY_LEVEL = 12'h40C;
  localparam logic [11:0] OFS_APPLIED_DUTY_LEVEL = 12'h4F6;
  localparam logic [11:0] OFS_TARGET_DUTY_LEVEL = 12'h506;
  localparam logic [11:0] OFS_ROTOR_RATE_PER_UNIT = 12'h5B2;
  localparam logic [11:0] OFS_SUPPLY_POWER_PER_UNIT = 12'h6F4;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Control word layout
  localparam int RATE_FIELD_LSB = 16;
  localparam int RATE_FIELD_MSB = 30;
  localparam int RATE_FIELD_W = RATE_FIELD_MSB - RATE_FIELD_LSB + 1;
  localparam int SOURCE_SEL_BIT = 15;

  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] MONITOR_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Per-unit full scale is two to the thirtieth
  localparam int PU_ONE_BIT = 30;
  localparam logic [14:0] RATE_FULL_SCALE = 15'h7FFF;

  // Monitor routed to the analog output
  typedef enum logic [2:0] {
    SCMR_DAC_COMMANDED = 3'h0,
    SCMR_DAC_APPLIED = 3'h1,
    SCMR_DAC_TARGET = 3'h2,
    SCMR_DAC_ROTOR = 3'h3,
    SCMR_DAC_POWER = 3'h4
  } scmr_dac_src_t;

endpackage

// ### hw/scmr_dac_scale.sv
// Maps a per-unit monitor word onto the analog output code so that
// per-unit one (full-scale voltage) gives the all-ones code.
module scmr_dac_scale #(
  parameter int DAC_WIDTH = 12
) (
  input wire logic [31:0] pu_word,
  output logic [DAC_WIDTH-1:0] dac_code
);

  localparam int TOP = scmr_pkg::PU_ONE_BIT;

  always_comb
  begin
    if (pu_word[31])
    begin
      // Negative per-unit values clip at zero volts
      dac_code = '0;
    end
    else if (pu_word[TOP])
    begin
      // At or above full scale clip at full-scale voltage
      dac_code = '1;
    end
    else
    begin
      dac_code = pu_word[TOP-1 -: DAC_WIDTH];
    end
  end

endmodule

// ### hw/scmr_regs.sv
// Overview of operation
// - Control bits 30..16: writable speed command, value/32767*100 percent.
// - Control bit 15 picks speed source: 0 input pin, 1 register command.
// - Read-only commanded duty word, percent is word/2^30*100.
// - Read-only applied duty word, same scaling, duty being driven now.
// - Read-only target duty word, same scaling, duty firmware aims for.
// - Read-only rotor speed word; hertz is word/2^30 times max speed/16.
// - Analog output full scale (3 V) equals per-unit one.
// - Read-only supply power word in per-unit; full scale is max power/4.
// - Power watts is word/2^30 times max power/4.
module scmr_regs #(
  parameter int DAC_WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port from the serial register front end
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [scmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scmr_pkg::DATA_W-1:0] reg_wdata,
  output logic [scmr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // Speed request from the analog, frequency or PWM decoder
  input wire logic [14:0] pin_rate_request,
  input wire logic control_update,
  // Monitor values from the control algorithm
  input wire logic [31:0] commanded_duty_in,
  input wire logic [31:0] applied_duty_in,
  input wire logic [31:0] target_duty_in,
  input wire logic [31:0] rotor_rate_in,
  input wire logic [31:0] supply_power_in,
  // Analog output routing
  input wire logic [2:0] dac_source_sel,
  // Results to the control algorithm and analog output
  output logic [14:0] rate_request,
  output logic rate_from_register,
  output logic [DAC_WIDTH-1:0] dac_code
);

  if (DAC_WIDTH < 1 || DAC_WIDTH > scmr_pkg::PU_ONE_BIT)
  begin : g_bad_width
    $error("DAC_WIDTH must lie between 1 and 30");
  end

  //////////////////////////////////////////////////////////////////////////
  // Control word

  logic [scmr_pkg::RATE_FIELD_W-1:0] digital_rate_request_field;
  logic [scmr_pkg::RATE_FIELD_W-1:0] next_digital_rate_request_field;
  logic speed_source_override;
  logic next_speed_source_override;

  always_comb
  begin
    next_digital_rate_request_field = digital_rate_request_field;
    next_speed_source_override = speed_source_override;
    // Only the listed control offset accepts a write
    if (reg_wr_en && reg_addr == scmr_pkg::OFS_SPEED_COMMAND_CONTROL)
    begin
      next_digital_rate_request_field =
        reg_wdata[scmr_pkg::RATE_FIELD_MSB:scmr_pkg::RATE_FIELD_LSB];
      next_speed_source_override =
        reg_wdata[scmr_pkg::SOURCE_SEL_BIT];
      // Bit 31 is accepted but not kept; it reads back as zero
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      digital_rate_request_field <=
        scmr_pkg::CONTROL_RESET[scmr_pkg::RATE_FIELD_MSB:
                                scmr_pkg::RATE_FIELD_LSB];
      speed_source_override <=
        scmr_pkg::CONTROL_RESET[scmr_pkg::SOURCE_SEL_BIT];
    end
    else
    begin
      digital_rate_request_field <= next_digital_rate_request_field;
      speed_source_override <= next_speed_source_override;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Applied speed request

  logic [14:0] next_rate_request;
  logic next_rate_from_register;

  always_comb
  begin
    next_rate_request = rate_request;
    next_rate_from_register = rate_from_register;
    // Source and command are sampled only at a control update
    if (control_update)
    begin
      next_rate_from_register = speed_source_override;
      if (speed_source_override)
      begin
        next_rate_request = digital_rate_request_field;
      end
      else
      begin
        next_rate_request = pin_rate_request;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rate_request <= '0;
      rate_from_register <= 1'b0;
    end
    else
    begin
      rate_request <= next_rate_request;
      rate_from_register <= next_rate_from_register;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Monitor words, written only by the algorithm side

  logic [31:0] commanded_duty_level;
  logic [31:0] applied_duty_level;
  logic [31:0] target_duty_level;
  logic [31:0] rotor_rate_per_unit;
  logic [31:0] supply_power_per_unit;
  logic [31:0] next_commanded_duty_level;
  logic [31:0] next_applied_duty_level;
  logic [31:0] next_target_duty_level;
  logic [31:0] next_rotor_rate_per_unit;
  logic [31:0] next_supply_power_per_unit;

  always_comb
  begin
    // Host writes never reach these words
    next_commanded_duty_level = commanded_duty_in;
    next_applied_duty_level = applied_duty_in;
    next_target_duty_level = target_duty_in;
    next_rotor_rate_per_unit = rotor_rate_in;
    next_supply_power_per_unit = supply_power_in;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      commanded_duty_level <= scmr_pkg::MONITOR_RESET;
      applied_duty_level <= scmr_pkg::MONITOR_RESET;
      target_duty_level <= scmr_pkg::MONITOR_RESET;
      rotor_rate_per_unit <= scmr_pkg::MONITOR_RESET;
      supply_power_per_unit <= scmr_pkg::MONITOR_RESET;
    end
    else
    begin
      commanded_duty_level <= next_commanded_duty_level;
      applied_duty_level <= next_applied_duty_level;
      target_duty_level <= next_target_duty_level;
      rotor_rate_per_unit <= next_rotor_rate_per_unit;
      supply_power_per_unit <= next_supply_power_per_unit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read

  logic [31:0] next_reg_rdata;
  logic next_reg_rd_valid;
  logic [31:0] control_readback;

  always_comb
  begin
    control_readback = scmr_pkg::READ_ZERO;
    control_readback[scmr_pkg::RATE_FIELD_MSB:scmr_pkg::RATE_FIELD_LSB] =
      digital_rate_request_field;
    control_readback[scmr_pkg::SOURCE_SEL_BIT] = speed_source_override;
    next_reg_rd_valid = reg_rd_en;
    next_reg_rdata = reg_rdata;
    if (reg_rd_en)
    begin
      if (reg_addr == scmr_pkg::OFS_SPEED_COMMAND_CONTROL)
      begin
        next_reg_rdata = control_readback;
      end
      else if (reg_addr == scmr_pkg::OFS_COMMANDED_DUTY_LEVEL)
      begin
        next_reg_rdata = commanded_duty_level;
      end
      else if (reg_addr == scmr_pkg::OFS_APPLIED_DUTY_LEVEL)
      begin
        next_reg_rdata = applied_duty_level;
      end
      else if (reg_addr == scmr_pkg::OFS_TARGET_DUTY_LEVEL)
      begin
        next_reg_rdata = target_duty_level;
      end
      else if (reg_addr == scmr_pkg::OFS_ROTOR_RATE_PER_UNIT)
      begin
        next_reg_rdata = rotor_rate_per_unit;
      end
      else if (reg_addr == scmr_pkg::OFS_SUPPLY_POWER_PER_UNIT)
      begin
        next_reg_rdata = supply_power_per_unit;
      end
      else
      begin
        next_reg_rdata = scmr_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      reg_rdata <= scmr_pkg::READ_ZERO;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      reg_rd_valid <= next_reg_rd_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog monitor output

  logic [31:0] dac_word;
  logic [DAC_WIDTH-1:0] scaled_code;
  logic [DAC_WIDTH-1:0] next_dac_code;

  always_comb
  begin
    case (scmr_pkg::scmr_dac_src_t'(dac_source_sel))
      scmr_pkg::SCMR_DAC_COMMANDED: dac_word = commanded_duty_level;
      scmr_pkg::SCMR_DAC_APPLIED: dac_word = applied_duty_level;
      scmr_pkg::SCMR_DAC_TARGET: dac_word = target_duty_level;
      scmr_pkg::SCMR_DAC_ROTOR: dac_word = rotor_rate_per_unit;
      scmr_pkg::SCMR_DAC_POWER: dac_word = supply_power_per_unit;
      default: dac_word = scmr_pkg::READ_ZERO;
    endcase
    next_dac_code = scaled_code;
  end

  scmr_dac_scale #(
    .DAC_WIDTH(DAC_WIDTH)
  ) u_dac_scale (
    .pu_word(dac_word),
    .dac_code(scaled_code)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dac_code <= '0;
    end
    else
    begin
      dac_code <= next_dac_code;
    end
  end

endmodule

// ### bench/scmr_host.sv
module scmr_host (
  input logic ref_clk,
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [11:0] reg_addr = 12'h000,
  output logic [31:0] reg_wdata = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // One access, strobed for reads and mapped-offset writes only; afterwards the bus carries inverted stale values
  task automatic access(logic wr, logic [11:0] a, logic [31:0] d);
    @(negedge ref_clk);
    reg_wr_en = wr && a inside {12'h0E8, 12'h40C, 12'h4F6, 12'h506,
      12'h5B2, 12'h6F4};
    reg_rd_en = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ### bench/scmr_regs_chk.sv
module scmr_regs_chk #(parameter int DAC_WIDTH = 12) (
  input logic ref_clk,
  input logic nrst,
  input logic reg_wr_en,
  input logic reg_rd_en,
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  input logic reg_rd_valid,
  input logic [14:0] pin_rate_request,
  input logic control_update,
  input logic [31:0] applied_duty_in,
  input logic [2:0] dac_source_sel,
  input logic [14:0] rate_request,
  input logic rate_from_register,
  input logic [DAC_WIDTH-1:0] dac_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the control word as written by the host
  logic [31:0] ctl;
  logic [31:0] next_ctl;
  always_comb
  begin
    next_ctl = ctl;
    if (!nrst)
      next_ctl = '0;
    else if (reg_wr_en && reg_addr == 12'h0E8)
      next_ctl = reg_wdata;
  end
  always_ff @(posedge ref_clk)
    ctl <= next_ctl;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_read_answer:
    assert property (reg_rd_en |=> reg_rd_valid) else $error("no valid");
  a_valid_cause:
    assert property (reg_rd_valid |-> $past(reg_rd_en)) else $error("stray");
  a_ctl_readback:
    assert property (reg_rd_en && reg_addr == 12'h0E8 |=>
      reg_rdata == ($past(ctl) & 32'h7FFF8000)) else $error("readback");
  a_unmapped_zero:
    assert property (reg_rd_en && reg_addr == 12'h0EC |=> reg_rdata == '0)
      else $error("unmapped");
  a_source_pick:
    assert property (control_update |=>
      rate_from_register == $past(ctl[15])) else $error("source");
  a_rate_value:
    assert property (control_update |=> rate_request == ($past(ctl[15]) ?
      $past(ctl[30:16]) : $past(pin_rate_request))) else $error("rate");
  a_rate_hold:
    assert property (!control_update |=> $stable(rate_request) &&
      $stable(rate_from_register)) else $error("hold");
  a_dac_full:
    assert property ((applied_duty_in == 32'h4000_0000) ##1
      (dac_source_sel == 3'h1) |=> dac_code == '1) else $error("dac");
endmodule
bind scmr_regs scmr_regs_chk #(.DAC_WIDTH(DAC_WIDTH)) u_chk (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid),
  .pin_rate_request(pin_rate_request),
  .control_update(control_update),
  .applied_duty_in(applied_duty_in),
  .dac_source_sel(dac_source_sel),
  .rate_request(rate_request),
  .rate_from_register(rate_from_register),
  .dac_code(dac_code)
);

// ### bench/speed_command_monitor_regs_tb.sv
module speed_command_monitor_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic control_update = 1'b0;
  logic [14:0] pin_rate_request = 15'h0000;
  logic [2:0] dac_source_sel = 3'h0;
  logic [31:0] mon [5] = '{default: 32'h0};
  logic [11:0] ofs [6] = '{12'h0E8, 12'h40C, 12'h4F6, 12'h506, 12'h5B2,
    12'h6F4};
  logic reg_wr_en, reg_rd_en, reg_rd_valid, rate_from_register;
  logic [11:0] reg_addr, dac_code;
  logic [31:0] reg_wdata, reg_rdata;
  logic [14:0] rate_request, f, p;
  logic [15:0] rate;
  logic [31:0] expq [$];
  logic [31:0] rd_exp;
  int errors = 0;
  int checks = 0;
  assign rate = {rate_from_register, rate_request};
  always #4 ref_clk = ~ref_clk;
  scmr_host u_host (
    .ref_clk(ref_clk),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata)
  );
  scmr_regs #(.DAC_WIDTH(12)) u_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .pin_rate_request(pin_rate_request),
    .control_update(control_update),
    .commanded_duty_in(mon[0]),
    .applied_duty_in(mon[1]),
    .target_duty_in(mon[2]),
    .rotor_rate_in(mon[3]),
    .supply_power_in(mon[4]),
    .dac_source_sel(dac_source_sel),
    .rate_request(rate_request),
    .rate_from_register(rate_from_register),
    .dac_code(dac_code)
  );
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    expq.push_back(e);
    u_host.access(1'b0, a, 32'h0);
  endtask
  task automatic upd();
    @(negedge ref_clk);
    control_update = 1'b1;
    @(negedge ref_clk);
    control_update = 1'b0;
  endtask
  // Read results are matched against the oldest noted expectation
  always @(negedge ref_clk)
  begin
    if (reg_rd_valid === 1'b1)
    begin
      rd_exp = expq.size() > 0 ? expq.pop_front() : 'x;
      check("rdata", reg_rdata, rd_exp);
    end
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(85889));
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    foreach (ofs[i])
      rd(ofs[i], 32'h0);
    check("dac", dac_code, 32'h0);
    $display("test reset done");
    f = 15'($urandom);
    p = 15'($urandom);
    pin_rate_request = p;
    u_host.access(1'b1, 12'h0E8, {1'b1, f, 1'b1, 15'h7FFF});
    rd(12'h0E8, {1'b0, f, 1'b1, 15'h0000});
    rd(12'h0EC, 32'h0);
    check("rate", rate, 32'h0);
    upd();
    check("rate", rate, {1'b1, f});
    u_host.access(1'b1, 12'h0E8, 32'h7FFF_0000);
    rd(12'h0E8, 32'h7FFF_0000);
    check("rate", rate, {1'b1, f});
    upd();
    check("rate", rate, {1'b0, p});
    $display("test speed done");
    u_host.access(1'b1, 12'h0E8, 32'h7FFF_8000);
    upd();
    check("rate", rate, 32'h0000_FFFF);
    nrst = 1'b0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    check("rate", rate, 32'h0);
    rd(12'h0E8, 32'h0);
    $display("test reset again done");
    foreach (mon[i])
      mon[i] = $urandom;
    foreach (mon[i])
      rd(ofs[i + 1], mon[i]);
    u_host.access(1'b1, 12'h40C, ~mon[0]);
    rd(12'h40C, mon[0]);
    $display("test monitor done");
    for (int s = 0; s < 8; s++)
    begin
      foreach (mon[i])
        mon[i] = (i == s) ? 32'h4000_0000 : 32'h8000_0000;
      dac_source_sel = 3'(s);
      repeat (3) @(negedge ref_clk);
      check("dac", dac_code, (s < 5) ? 32'h0000_0FFF : 32'h0);
    end
    dac_source_sel = 3'h1;
    mon[1] = 32'h2000_0000;
    repeat (3) @(negedge ref_clk);
    check("dac", dac_code, 32'h0000_0800);
    mon[1] = 32'hC000_0000;
    repeat (3) @(negedge ref_clk);
    check("dac", dac_code, 32'h0);
    $display("test dac done");
    check("pending", 32'(expq.size()), 32'h0);
    report_and_stop();
  end
endmodule
